// *** inc/flash_pkg.sv ***
/*
  Shared constants for the serial flash page write/program link: command
  codes, array geometry, lock and status bit positions, timing counts.
  Assumes a 100 MHz system clock on both ends.
*/
package flash_pkg;
  localparam int CLK_MHZ = 100;
  // Command codes
  localparam logic [7:0] CMD_WREN       = 8'h06;
  localparam logic [7:0] CMD_WRDI       = 8'h04;
  localparam logic [7:0] CMD_RDSR       = 8'h05;
  localparam logic [7:0] CMD_PAGE_WRITE = 8'h0a;
  localparam logic [7:0] CMD_PAGE_PROG  = 8'h02;
  localparam logic [7:0] CMD_LOCK_WR    = 8'he5;
  localparam logic [7:0] CMD_LOCK_RD    = 8'he8;
  // Geometry of the modelled array
  localparam int PAGE_BYTES  = 256;
  localparam int MEM_ADDR_W  = 12;
  localparam int PAGE_W      = 4;
  localparam int SEC_W       = 2;
  localparam int NUM_PAGES   = 16;
  localparam int NUM_SECTORS = 4;
  localparam int MEM_BYTES   = 4096;
  // Lock and status bit positions, reset values
  localparam int LOCK_WR_BIT   = 0;
  localparam int LOCK_DOWN_BIT = 1;
  localparam logic [1:0] LOCK_RESET = 2'h0;
  localparam int STAT_WIP_BIT  = 0;
  localparam int STAT_WEL_BIT  = 1;
  localparam logic [7:0] ERASED = 8'hff;
  // Self-timed cycle lengths
  localparam int TMR_W          = 20;
  localparam int PROG_TIME_US   = 50;
  localparam int WRITE_TIME_US  = 100;
  localparam int PROG_CYCLES    = PROG_TIME_US * CLK_MHZ;
  localparam int WRITE_CYCLES   = WRITE_TIME_US * CLK_MHZ;
  // Host link timing: SCLK_HALF_NS in ns, the rest in system clock cycles
  localparam int SCLK_HALF_NS   = 80;
  localparam int SCLK_HALF      = SCLK_HALF_NS * CLK_MHZ / 1000;
  localparam int DESEL_CYCLES   = 16;

  typedef enum logic [1:0] {ST_IDLE, ST_COMMIT, ST_WAIT} dev_state_t;
  typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_TAIL, H_GAP} host_state_t;
endpackage

// *** inc/flash_link_if.sv ***
/*
  Serial link between a bus master and the flash device: select, clock,
  serial in, serial out. All signals are one-way; the bench joins the ends.
*/
`timescale 1ns/1ns
interface flash_link_if;
  logic sel_n;
  logic sclk;
  logic serial_in_line;
  logic serial_out;
  modport dev  (input sel_n, sclk, serial_in_line, output serial_out);
  modport host (output sel_n, sclk, serial_in_line, input serial_out);
endinterface

// *** hdl/flash_dev.sv ***
/*
  Flash device end: command shifter, write enable latch, sector lock
  register, page buffer and self-timed page write / page program sequencer.
  Assumes the link pins are asynchronous to sys_clk_in and that the link
  clock is much slower than the system clock.
*/
// Functional notes
// R1 - Write lock set: refuse changes to sector
// R2 - Write lock clear: sector changes proceed
// R3 - Page commands need write enable latch set
// R4 - Host sends command, address, data, select low
// R5 - Page write rewrites whole page, keeps rest
// R6 - Data past page end wraps to offset zero
// R7 - Over 256 bytes: last 256 kept
// R8 - Fewer bytes: only addressed bytes change
// R9 - Select rise off byte boundary discards command
// R10 - Host holds select low whole sequence
// R11 - Self-timed cycle starts at select rise
// R12 - Status readable, in-progress flag while cycling
// R13 - Write enable latch cleared before cycle ends
// R14 - Page write refused on hardware/software protection
// R15 - Page program refused on hardware protection
// R16 - Page commands rejected during running cycle
// R17 - Page program only clears bits
// R18 - Host should send consecutive bytes together
// R19 - Address bits A23-A19 ignored
// R20 - Lock-down freezes lock bits until power-up
// R21 - MSB first, sampled on rising link clock
`timescale 1ns/1ns
module flash_dev
  import flash_pkg::*;
#(
  parameter int PROG_CYC  = PROG_CYCLES,
  parameter int WRITE_CYC = WRITE_CYCLES
) (
  input  wire logic                   sys_clk_in,
  input  wire logic                   rst_n_in,
  flash_link_if.dev                   link,
  input  wire logic [NUM_SECTORS-1:0] hw_prot_in,
  input  wire logic [NUM_SECTORS-1:0] sw_prot_in,
  input  wire logic [MEM_ADDR_W-1:0]  peek_addr_in,
  output logic      [7:0]             peek_data_out,
  output logic                        wip_out,
  output logic                        wel_out
);
  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic sel_s1_ff, sel_s2_ff, sel_s3_ff;
  logic clk_s1_ff, clk_s2_ff, clk_s3_ff;
  logic din_s1_ff, din_s2_ff;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      {sel_s1_ff, sel_s2_ff, sel_s3_ff} <= 3'h7;
      {clk_s1_ff, clk_s2_ff, clk_s3_ff} <= 3'h0;
      {din_s1_ff, din_s2_ff}            <= 2'h0;
    end else begin
      {sel_s1_ff, sel_s2_ff, sel_s3_ff} <= {link.sel_n, sel_s1_ff, sel_s2_ff};
      {clk_s1_ff, clk_s2_ff, clk_s3_ff} <= {link.sclk, clk_s1_ff, clk_s2_ff};
      {din_s1_ff, din_s2_ff}            <= {link.serial_in_line, din_s1_ff};
    end
  end

  logic       sel_fall, sel_rise, sclk_rise, sclk_fall, byte_done;
  logic [2:0] bit_cnt_ff, byte_cnt_ff;
  logic [7:0] shift_ff, cmd_ff, rx_byte, lock_data_ff;
  logic [23:0] addr_ff, addr_now;
  logic [1:0] data_cnt_ff;
  logic [7:0] wr_ptr_ff;
  logic       rej_ff;
  dev_state_t st_ff;
  logic       busy;

  assign sel_fall  = ~sel_s2_ff & sel_s3_ff;
  assign sel_rise  = sel_s2_ff & ~sel_s3_ff;
  assign sclk_rise = clk_s2_ff & ~clk_s3_ff & ~sel_s2_ff;
  assign sclk_fall = ~clk_s2_ff & clk_s3_ff & ~sel_s2_ff;
  assign rx_byte   = {shift_ff[6:0], din_s2_ff};  // R21
  assign byte_done = sclk_rise & (bit_cnt_ff == 3'h7);
  assign addr_now  = {addr_ff[15:0], rx_byte};
  assign busy      = (st_ff != ST_IDLE);

  // ----------------------------------------------------------------
  // Command, address and data byte framing
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      bit_cnt_ff   <= 3'h0;
      byte_cnt_ff  <= 3'h0;
      shift_ff     <= 8'h00;
      cmd_ff       <= 8'h00;
      addr_ff      <= 24'h000000;
      data_cnt_ff  <= 2'h0;
      wr_ptr_ff    <= 8'h00;
      lock_data_ff <= 8'h00;
      rej_ff       <= 1'b0;
    end else if (sel_fall) begin
      bit_cnt_ff  <= 3'h0;
      byte_cnt_ff <= 3'h0;
      data_cnt_ff <= 2'h0;
      rej_ff      <= busy;  // R16
    end else if (sclk_rise) begin
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      shift_ff   <= rx_byte;
      if (bit_cnt_ff == 3'h7) begin
        if (byte_cnt_ff != 3'h4)
          byte_cnt_ff <= byte_cnt_ff + 3'h1;
        case (byte_cnt_ff)
          3'h0: cmd_ff <= rx_byte;
          3'h1, 3'h2: addr_ff <= addr_now;
          3'h3: begin
            addr_ff   <= addr_now;
            wr_ptr_ff <= rx_byte;  // R6
          end
          default: begin
            wr_ptr_ff <= wr_ptr_ff + 8'h01;  // R6 R7
            if (data_cnt_ff != 2'h2)
              data_cnt_ff <= data_cnt_ff + 2'h1;
            if (data_cnt_ff == 2'h0)
              lock_data_ff <= rx_byte;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Command acceptance at select rise
  // ----------------------------------------------------------------
  logic [1:0]        lock_ff [NUM_SECTORS];
  logic              wel_ff;
  logic [SEC_W-1:0]  sec;
  logic [PAGE_W-1:0] pg;
  logic              page_cmd, seq_ok, blocked, start_op, lock_go;

  // Only the low array address bits are decoded, so A23-A19 never matter
  assign sec      = addr_ff[MEM_ADDR_W-1 -: SEC_W];  // R19
  assign pg       = addr_ff[MEM_ADDR_W-1 -: PAGE_W];
  assign page_cmd = (cmd_ff == CMD_PAGE_WRITE) | (cmd_ff == CMD_PAGE_PROG);
  assign seq_ok   = sel_rise & ~rej_ff & ~busy & wel_ff & (bit_cnt_ff == 3'h0);  // R3 R9 R16
  assign blocked  = hw_prot_in[sec] | lock_ff[sec][LOCK_WR_BIT]  // R1 R2 R15
                  | ((cmd_ff == CMD_PAGE_WRITE) & sw_prot_in[sec]);  // R14
  assign start_op = seq_ok & page_cmd & (data_cnt_ff != 2'h0) & ~blocked;  // R11
  assign lock_go  = seq_ok & (cmd_ff == CMD_LOCK_WR) & (data_cnt_ff == 2'h1)
                  & ~lock_ff[sec][LOCK_DOWN_BIT];  // R20

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      wel_ff <= 1'b0;
    end else if (start_op | lock_go) begin
      wel_ff <= 1'b0;  // R13
    end else if (byte_done & (byte_cnt_ff == 3'h0) & ~busy) begin
      if (rx_byte == CMD_WREN)
        wel_ff <= 1'b1;  // R3
      else if (rx_byte == CMD_WRDI)
        wel_ff <= 1'b0;
    end
  end

  // Lock bits are volatile; only a reset (power-up) releases lock-down
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NUM_SECTORS; i++)
        lock_ff[i] <= LOCK_RESET;
    end else if (lock_go) begin
      lock_ff[sec] <= lock_data_ff[1:0];  // R20
    end
  end

  // ----------------------------------------------------------------
  // Page buffer
  // ----------------------------------------------------------------
  logic [7:0]            page_buf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] mask_ff;
  logic                  buf_wr;

  assign buf_wr = byte_done & (byte_cnt_ff == 3'h4) & page_cmd & ~rej_ff;

  always_ff @(posedge sys_clk_in) begin
    if (buf_wr)
      page_buf[wr_ptr_ff] <= rx_byte;  // R7
  end

  // The mask is not cleared while a cycle runs, since the commit reads it
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in)
      mask_ff <= '0;
    else if (sel_fall & ~busy)
      mask_ff <= '0;
    else if (buf_wr)
      mask_ff[wr_ptr_ff] <= 1'b1;  // R8
  end

  // ----------------------------------------------------------------
  // Self-timed cycle: commit one byte a clock, then wait out the timer
  // ----------------------------------------------------------------
  logic [7:0]           mem [MEM_BYTES];
  logic [NUM_PAGES-1:0] page_valid_ff;
  logic [TMR_W-1:0]     timer_ff;
  logic [7:0]           idx_ff, old_byte, new_byte;
  logic [PAGE_W-1:0]    page_ff;
  logic                 op_write_ff;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      st_ff       <= ST_IDLE;
      timer_ff    <= '0;
      idx_ff      <= 8'h00;
      page_ff     <= '0;
      op_write_ff <= 1'b0;
    end else begin
      if (timer_ff != '0)
        timer_ff <= timer_ff - TMR_W'(1);
      case (st_ff)
        ST_IDLE: begin
          if (start_op) begin
            st_ff       <= ST_COMMIT;  // R11
            idx_ff      <= 8'h00;
            page_ff     <= pg;
            op_write_ff <= (cmd_ff == CMD_PAGE_WRITE);
            timer_ff    <= (cmd_ff == CMD_PAGE_WRITE) ? TMR_W'(WRITE_CYC) : TMR_W'(PROG_CYC);
          end
        end
        ST_COMMIT: begin
          idx_ff <= idx_ff + 8'h01;
          if (idx_ff == 8'hff)
            st_ff <= ST_WAIT;
        end
        ST_WAIT: begin
          if (timer_ff == '0)
            st_ff <= ST_IDLE;  // R12
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // Unwritten pages read as erased, so the array needs no reset
  assign old_byte = page_valid_ff[page_ff] ? mem[{page_ff, idx_ff}] : ERASED;

  always_comb begin
    new_byte = old_byte;  // R8
    if (mask_ff[idx_ff]) begin
      if (op_write_ff)
        new_byte = page_buf[idx_ff];  // R5
      else
        new_byte = old_byte & page_buf[idx_ff];  // R17
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (st_ff == ST_COMMIT)
      mem[{page_ff, idx_ff}] <= new_byte;  // R2
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in)
      page_valid_ff <= '0;
    else if ((st_ff == ST_COMMIT) & (idx_ff == 8'hff))
      page_valid_ff[page_ff] <= 1'b1;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in)
      peek_data_out <= 8'h00;
    else
      peek_data_out <= page_valid_ff[peek_addr_in[MEM_ADDR_W-1 -: PAGE_W]] ? mem[peek_addr_in] : ERASED;
  end

  // ----------------------------------------------------------------
  // Status and lock readback, shifted out on falling link clock
  // ----------------------------------------------------------------
  logic [7:0] status, out_sr_ff;
  logic       sdo_ff;

  always_comb begin
    status               = 8'h00;
    status[STAT_WIP_BIT] = busy;  // R12
    status[STAT_WEL_BIT] = wel_ff;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      out_sr_ff <= 8'h00;
      sdo_ff    <= 1'b0;
    end else if (sel_s2_ff) begin
      sdo_ff <= 1'b0;
    end else if (byte_done) begin
      // Status reloads every byte so polling sees the flag drop live
      if ((byte_cnt_ff == 3'h0) ? (rx_byte == CMD_RDSR) : (cmd_ff == CMD_RDSR))
        out_sr_ff <= status;  // R12
      else if ((byte_cnt_ff == 3'h3) & (cmd_ff == CMD_LOCK_RD))
        out_sr_ff <= {6'h00, lock_ff[addr_now[MEM_ADDR_W-1 -: SEC_W]]};
    end else if (sclk_fall) begin
      sdo_ff    <= out_sr_ff[7];  // R21
      out_sr_ff <= {out_sr_ff[6:0], 1'b0};
    end
  end

  assign link.serial_out = sdo_ff;
  assign wip_out         = busy;
  assign wel_out         = wel_ff;
endmodule // flash_dev

// *** hdl/flash_host.sv ***
/*
  Bus master end: frames one command sequence per request, generating the
  link clock by a divider of the system clock (mode 0, MSB first).
  Assumes the user holds request fields stable until done and offers the
  next write byte on wr_data_in whenever wr_take_out pulses.
*/
`timescale 1ns/1ns
module flash_host
  import flash_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  flash_link_if.host       link,
  input  wire logic        start_in,
  input  wire logic [7:0]  cmd_in,
  input  wire logic        addr_en_in,
  input  wire logic [23:0] addr_in,
  input  wire logic [9:0]  wr_cnt_in,
  input  wire logic [9:0]  rd_cnt_in,
  input  wire logic [7:0]  wr_data_in,
  output logic             busy_out,
  output logic             wr_take_out,
  output logic [7:0]       rd_data_out,
  output logic             rd_valid_out,
  output logic             done_out
);
  // ----------------------------------------------------------------
  // Serial out synchroniser
  // ----------------------------------------------------------------
  logic sdo_s1_ff, sdo_s2_ff;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in)
      {sdo_s1_ff, sdo_s2_ff} <= 2'h0;
    else
      {sdo_s1_ff, sdo_s2_ff} <= {link.serial_out, sdo_s1_ff};
  end

  // ----------------------------------------------------------------
  // Sequence framing
  // ----------------------------------------------------------------
  host_state_t st_ff;
  logic [7:0]  cnt_ff, tx_sr_ff, rx_sr_ff, nxt_byte;
  logic [2:0]  bit_ff;
  logic [11:0] idx_ff, nxt_idx, n_addr, wr_end, tot;
  logic [23:0] addr_ff;
  logic        sel_n_ff, sclk_ff, sdi_ff, byte_end, nxt_is_wr;

  assign n_addr    = addr_en_in ? 12'h003 : 12'h000;
  assign wr_end    = 12'h001 + n_addr + {2'h0, wr_cnt_in};
  assign tot       = wr_end + {2'h0, rd_cnt_in};
  assign nxt_idx   = idx_ff + 12'h001;
  assign byte_end  = (st_ff == H_HIGH) & (cnt_ff == 8'h00) & (bit_ff == 3'h7);
  assign nxt_is_wr = (nxt_idx > n_addr) & (nxt_idx < wr_end);

  always_comb begin
    nxt_byte = 8'h00;
    if (nxt_idx <= n_addr) begin
      case (nxt_idx[1:0])
        2'h1:    nxt_byte = addr_ff[23:16];
        2'h2:    nxt_byte = addr_ff[15:8];
        default: nxt_byte = addr_ff[7:0];
      endcase
    end else if (nxt_is_wr) begin
      nxt_byte = wr_data_in;
    end
  end

  // Select only rises after the last bit, on a byte boundary
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      st_ff        <= H_IDLE;
      cnt_ff       <= 8'h00;
      bit_ff       <= 3'h0;
      idx_ff       <= 12'h000;
      tx_sr_ff     <= 8'h00;
      rx_sr_ff     <= 8'h00;
      addr_ff      <= 24'h000000;
      sel_n_ff     <= 1'b1;
      sclk_ff      <= 1'b0;
      sdi_ff       <= 1'b0;
      rd_data_out  <= 8'h00;
      rd_valid_out <= 1'b0;
      done_out     <= 1'b0;
    end else begin
      rd_valid_out <= 1'b0;
      done_out     <= 1'b0;
      if (cnt_ff != 8'h00)
        cnt_ff <= cnt_ff - 8'h01;
      case (st_ff)
        H_IDLE: begin
          if (start_in) begin
            st_ff    <= H_LOW;  // R4
            sel_n_ff <= 1'b0;
            addr_ff  <= addr_in;
            tx_sr_ff <= cmd_in;
            sdi_ff   <= cmd_in[7];  // R21
            idx_ff   <= 12'h000;
            bit_ff   <= 3'h0;
            cnt_ff   <= 8'(SCLK_HALF - 1);
          end
        end
        H_LOW: begin
          if (cnt_ff == 8'h00) begin
            st_ff   <= H_HIGH;
            sclk_ff <= 1'b1;
            cnt_ff  <= 8'(SCLK_HALF - 1);
          end
        end
        H_HIGH: begin
          if (cnt_ff == 8'h00) begin
            sclk_ff  <= 1'b0;
            cnt_ff   <= 8'(SCLK_HALF - 1);
            rx_sr_ff <= {rx_sr_ff[6:0], sdo_s2_ff};
            bit_ff   <= bit_ff + 3'h1;
            st_ff    <= H_LOW;
            if (bit_ff == 3'h7) begin
              if (idx_ff >= wr_end) begin
                rd_data_out  <= {rx_sr_ff[6:0], sdo_s2_ff};
                rd_valid_out <= 1'b1;
              end
              if (nxt_idx == tot) begin
                st_ff <= H_TAIL;
              end else begin
                idx_ff   <= nxt_idx;  // R18
                tx_sr_ff <= nxt_byte;
                sdi_ff   <= nxt_byte[7];
              end
            end else begin
              tx_sr_ff <= {tx_sr_ff[6:0], 1'b0};
              sdi_ff   <= tx_sr_ff[6];
            end
          end
        end
        H_TAIL: begin
          if (cnt_ff == 8'h00) begin
            sel_n_ff <= 1'b1;  // R9 R10
            st_ff    <= H_GAP;
            cnt_ff   <= 8'(DESEL_CYCLES - 1);
          end
        end
        H_GAP: begin
          if (cnt_ff == 8'h00) begin
            st_ff    <= H_IDLE;
            done_out <= 1'b1;
          end
        end
        default: st_ff <= H_IDLE;
      endcase
    end
  end

  assign wr_take_out         = byte_end & (nxt_idx != tot) & nxt_is_wr;
  assign busy_out            = (st_ff != H_IDLE);
  assign link.sel_n          = sel_n_ff;
  assign link.sclk           = sclk_ff;
  assign link.serial_in_line = sdi_ff;
endmodule // flash_host

// *** bench/flash_link_sva.sv ***
/* Checker for the host/device serial link and the device status outputs.
   Assumes it is instantiated beside the interface that joins the two ends. */
`timescale 1ns/1ns
module flash_link_sva #(
  parameter int PROG_CYC  = 5000,
  parameter int WRITE_CYC = 10000
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic serial_in_line,
  input wire logic serial_out,
  input wire logic wip_out,
  input wire logic wel_out
);
  logic [11:0] bits_ff;
  logic [11:0] last_ff;
  logic [19:0] wcnt_ff;
  logic        sclk_q_ff;
  logic        sel_q_ff;
  // --------------------------------
  // Frame bit and cycle counters
  // --------------------------------
  always_ff @(posedge sys_clk_in) sclk_q_ff <= sclk;
  always_ff @(posedge sys_clk_in) sel_q_ff <= sel_n;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || sel_n) bits_ff <= 12'h000;
    else if (sclk && !sclk_q_ff) bits_ff <= bits_ff + 12'h001;
  end
  // Kept after select rises, since the device acts a few clocks later
  always_ff @(posedge sys_clk_in) begin
    if (sel_n && !sel_q_ff) last_ff <= bits_ff;
  end
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || !wip_out) wcnt_ff <= 20'h00000;
    else wcnt_ff <= wcnt_ff + 20'h00001;
  end
  // --------------------------------
  // Properties
  // --------------------------------
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  AST_SEL_ON_BYTE: assert property ($rose(sel_n) |-> bits_ff[2:0] == 3'h0 && bits_ff != 12'h000)
    else $error("select released off a byte boundary");
  AST_WIP_FRAME: assert property ($rose(wip_out) |-> sel_n && last_ff[2:0] == 3'h0 && last_ff >= 12'h028)
    else $error("page cycle started without a whole page frame");
  AST_WEL_DROP: assert property ($rose(wip_out) |-> !wel_out)
    else $error("write enable still set as the cycle starts");
  AST_WIP_LEN: assert property ($fell(wip_out) |-> wcnt_ff == PROG_CYC + 1 || wcnt_ff == WRITE_CYC + 1)
    else $error("self-timed cycle has the wrong length");
  AST_WEL_QUIET: assert property (wip_out |=> !$rose(wel_out))
    else $error("write enable set during a running cycle");
  AST_SCLK_IDLE: assert property (sel_n |-> !sclk)
    else $error("link clock runs while deselected");
  AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("link clock high phase is not 8 clocks");
  AST_SIN_STABLE: assert property (sclk && $past(sclk) |-> $stable(serial_in_line))
    else $error("serial input moved while link clock high");
  cover property ($rose(wip_out));
  cover property ($fell(wel_out));
  cover property ($rose(sel_n) && bits_ff > 12'h800);
endmodule // flash_link_sva

// *** bench/tb.sv ***
/* Testbench: host and device joined by the link, plus a second device driven bit by bit.
   Assumes flash_pkg, flash_link_if, the design modules and the checker compile first. */
`timescale 1ns/1ns
module tb;
  import flash_pkg::*;
  typedef struct {logic [7:0] c; logic [23:0] a; int n; logic [7:0] sd; logic [3:0] hw; logic [3:0] sw;
                  logic ok;} row_t;
  logic        clk = 1'b0, rst_n = 1'b0, start = 1'b0, aen = 1'b0;
  logic        busy, take, rvld, done, write_in_progress_flag, write_enable_latch, wip2, wel2;
  logic [7:0]  cmd = 8'h00, seed = 8'h00, rd_last = 8'h00;
  logic [7:0]  wdat, rdat, peek_d, peek_d2;
  logic [23:0] addr = 24'h000000;
  logic [9:0]  wcnt = 10'h000, rcnt = 10'h000, widx = 10'h000;
  logic [3:0]  hw = 4'h0, sw = 4'h0;
  logic [11:0] peek = 12'h000;
  logic [7:0]  mem [4096];
  int          n_mismatch = 0, check_count = 0, cyc = 0;
  row_t        rows [8];
  flash_link_if link ();
  flash_link_if link2 ();
  flash_dev #(.PROG_CYC(300), .WRITE_CYC(400)) flash_dev_i (.sys_clk_in(clk), .rst_n_in(rst_n), .link(link),
    .hw_prot_in(hw), .sw_prot_in(sw), .peek_addr_in(peek), .peek_data_out(peek_d), .wip_out(write_in_progress_flag), .wel_out(write_enable_latch));
  // Default cycle lengths: the bench resets this one mid-cycle
  flash_dev flash_dev_i2 (.sys_clk_in(clk), .rst_n_in(rst_n), .link(link2),
    .hw_prot_in(hw), .sw_prot_in(sw), .peek_addr_in(peek), .peek_data_out(peek_d2), .wip_out(wip2),
    .wel_out(wel2));
  flash_host flash_host_i (.sys_clk_in(clk), .rst_n_in(rst_n), .link(link), .start_in(start), .cmd_in(cmd),
    .addr_en_in(aen), .addr_in(addr), .wr_cnt_in(wcnt), .rd_cnt_in(rcnt), .wr_data_in(wdat), .busy_out(busy),
    .wr_take_out(take), .rd_data_out(rdat), .rd_valid_out(rvld), .done_out(done));
  flash_link_sva #(.PROG_CYC(300), .WRITE_CYC(400)) flash_link_sva_i (.sys_clk_in(clk), .rst_n_in(rst_n),
    .sel_n(link.sel_n), .sclk(link.sclk), .serial_in_line(link.serial_in_line), .serial_out(link.serial_out),
    .wip_out(write_in_progress_flag), .wel_out(write_enable_latch));
  // Data byte i of a sequence is seed ^ i[7:0] ^ i[9:8], so wrapped and overrun bytes are told apart
  assign wdat = seed ^ widx[7:0] ^ {6'h00, widx[9:8]};
  always @(posedge clk) widx <= start ? 10'h000 : widx + {9'h000, take};
  always @(posedge clk) if (rvld) rd_last <= rdat;
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_mismatch++;
      complete_run();
    end
  end
  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic [7:0] c, input logic ae, input logic [23:0] a, input int nw, input int nr,
                      input logic [7:0] sd);
    int k;
    k = 0;
    @(posedge clk);
    cmd <= c;
    aen <= ae;
    addr <= a;
    wcnt <= nw[9:0];
    rcnt <= nr[9:0];
    seed <= sd;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    do begin
      @(negedge clk);
      k++;
    end while (done !== 1'b1 && k < 40000);
    chk({busy, done}, 2'h1);
  endtask
  task automatic poll_idle;
    int k;
    k = 0;
    do begin
      xfer(CMD_RDSR, 1'b0, 24'h000000, 0, 1, 8'h00);
      k++;
    end while (rd_last[STAT_WIP_BIT] !== 1'b0 && k < 20);
  endtask
  task automatic chk_page(input logic [3:0] p);
    for (int i = 0; i < 256; i++) begin
      @(posedge clk);
      peek <= {p, i[7:0]};
      @(posedge clk);
      @(negedge clk);
      chk(peek_d, mem[{p, i[7:0]}]);
    end
  endtask
  task automatic page_op(input logic [7:0] c, input logic [23:0] a, input int n, input logic [7:0] sd,
                         input logic wen, input logic ok);
    logic [11:0] ad;
    logic [7:0]  d;
    if (wen) xfer(CMD_WREN, 1'b0, 24'h000000, 0, 0, 8'h00);
    xfer(c, 1'b1, a, n, 0, sd);
    xfer(CMD_RDSR, 1'b0, 24'h000000, 0, 1, 8'h00);
    chk(rd_last, ok ? 8'h01 : {6'h00, wen, 1'b0});
    poll_idle();
    for (int i = 0; i < n; i++) begin
      ad = {a[11:8], a[7:0] + i[7:0]};
      d = sd ^ i[7:0] ^ {6'h00, i[9:8]};
      if (ok) mem[ad] = (c == CMD_PAGE_PROG) ? (mem[ad] & d) : d;
    end
    chk_page(a[11:8]);
  endtask
  task automatic lock_wr(input logic [23:0] a, input logic [7:0] v);
    xfer(CMD_WREN, 1'b0, 24'h000000, 0, 0, 8'h00);
    xfer(CMD_LOCK_WR, 1'b1, a, 1, 0, v);
  endtask
  // Bit-banged master for the second device, so a frame can end mid-byte
  task automatic bb_frame(input logic [47:0] b, input int nbits);
    @(posedge clk);
    link2.sel_n <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      @(posedge clk);
      link2.serial_in_line <= b[47 - i];
      repeat (8) @(posedge clk);
      link2.sclk <= 1'b1;
      repeat (8) @(posedge clk);
      link2.sclk <= 1'b0;
    end
    repeat (8) @(posedge clk);
    link2.sel_n <= 1'b1;
    link2.serial_in_line <= ~link2.serial_in_line;
    repeat (24) @(posedge clk);
  endtask
  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    link2.sel_n = 1'b1;
    link2.sclk = 1'b0;
    link2.serial_in_line = 1'b0;
    foreach (mem[i]) mem[i] = ERASED;
    rows = '{'{CMD_PAGE_WRITE, 24'h000010, 4, 8'h5a, 4'h0, 4'h0, 1'b1},
             '{CMD_PAGE_PROG, 24'hf80012, 3, 8'h0f, 4'h0, 4'h0, 1'b1},
             '{CMD_PAGE_WRITE, 24'h0001fe, 4, 8'ha0, 4'h0, 4'h0, 1'b1},
             '{CMD_PAGE_PROG, 24'h000300, 2, 8'h00, 4'h1, 4'h0, 1'b0},
             '{CMD_PAGE_WRITE, 24'h000400, 2, 8'h11, 4'h0, 4'h2, 1'b0},
             '{CMD_PAGE_PROG, 24'h000500, 2, 8'h0c, 4'h0, 4'h2, 1'b1},
             '{CMD_PAGE_WRITE, 24'h000800, 1, 8'h22, 4'h4, 4'h0, 1'b0},
             '{CMD_PAGE_PROG, 24'h000010, 1, 8'hf0, 4'h0, 4'h0, 1'b1}};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      @(posedge clk);
      hw <= rows[i].hw;
      sw <= rows[i].sw;
      page_op(rows[i].c, rows[i].a, rows[i].n, rows[i].sd, 1'b1, rows[i].ok);
    end
    page_op(CMD_PAGE_WRITE, 24'h000680, 258, 8'h77, 1'b1, 1'b1);
    xfer(CMD_WRDI, 1'b0, 24'h000000, 0, 0, 8'h00);
    page_op(CMD_PAGE_WRITE, 24'h000900, 2, 8'h99, 1'b0, 1'b0);
    xfer(CMD_WREN, 1'b0, 24'h000000, 0, 0, 8'h00);
    xfer(CMD_PAGE_PROG, 1'b1, 24'h000700, 1, 0, 8'h0f);
    xfer(CMD_PAGE_WRITE, 1'b1, 24'h000700, 1, 0, 8'hc3);
    poll_idle();
    mem[12'h700] = 8'h0f;
    chk_page(4'h7);
    lock_wr(24'h000c00, 8'h01);
    page_op(CMD_PAGE_WRITE, 24'h000c10, 2, 8'h44, 1'b1, 1'b0);
    lock_wr(24'h000c00, 8'h03);
    lock_wr(24'h000c00, 8'h00);
    xfer(CMD_LOCK_RD, 1'b1, 24'h000c00, 0, 1, 8'h00);
    chk(rd_last, 8'h03);
    for (int e = 1; e >= 0; e--) begin
      bb_frame({CMD_WREN, 40'h0000000000}, 8);
      chk(wel2, 1'b1);
      bb_frame({CMD_PAGE_PROG, 24'h000020, 8'h3c, 8'ha5}, e ? 43 : 40);
      @(negedge clk);
      chk({wip2, wel2}, e ? 2'h1 : 2'h2);
      repeat (400) @(posedge clk);
      peek <= 12'h020;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(peek_d2, e ? 8'hff : 8'h3c);
    end
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    xfer(CMD_LOCK_RD, 1'b1, 24'h000c00, 0, 1, 8'h00);
    chk(rd_last, 8'h00);
    complete_run();
  end
endmodule // tb
